// ### rtl/pcl_params.svh
`ifndef PCL_PARAMS_SVH
`define PCL_PARAMS_SVH

// ****************************************
// timing, given in ns, us or MHz and converted to system clock cycles
// ****************************************
`define PCL_CLK_PS        5000
`define PCL_T_CF2ST_NS    600
`define PCL_CHK_CYC       ((`PCL_T_CF2ST_NS * 1000) / `PCL_CLK_PS + 3)
`define PCL_T_CFG_NS      2000
`define PCL_CFG_CYC       ((`PCL_T_CFG_NS * 1000 + `PCL_CLK_PS - 1) / `PCL_CLK_PS)
`define PCL_T_CF2CK_US    1506
`define PCL_CF2CK_CYC     ((`PCL_T_CF2CK_US * 1000000 + `PCL_CLK_PS - 1) / `PCL_CLK_PS)
`define PCL_T_STATUS_US   1506
`define PCL_STATUS_CYC    ((`PCL_T_STATUS_US * 1000000) / `PCL_CLK_PS)
`define PCL_T_ST2CK_US    2
`define PCL_ST2CK_CYC     ((`PCL_T_ST2CK_US * 1000000 + `PCL_CLK_PS - 1) / `PCL_CLK_PS)
`define PCL_T_CD2UM_US    437
`define PCL_CD2UM_CYC     ((`PCL_T_CD2UM_US * 1000000 + `PCL_CLK_PS - 1) / `PCL_CLK_PS)
`define PCL_CCLK_MAX_MHZ  100
`define PCL_CCLK_MIN_PS   (1000000 / `PCL_CCLK_MAX_MHZ)
`define PCL_CD2CU_CYC     ((4 * `PCL_CCLK_MIN_PS + `PCL_CLK_PS - 1) / `PCL_CLK_PS)
`define PCL_USER_PERIODS  8576
`define PCL_DIV           4
`define PCL_HALF          (`PCL_DIV / 2)
`define PCL_CNT_W         20
`define PCL_WORD_W        32
`endif

// ### rtl/pcl_pkg.sv
package pcl_pkg;
  typedef enum {
    ST_IDLE, ST_PULSE, ST_RELEASE, ST_SETTLE, ST_LOAD, ST_GAP, ST_INIT, ST_DONE, ST_FAIL
  } pcl_state_t;
  typedef logic [31:0] pcl_word_t;
endpackage

// ### rtl/pcl_host.sv
`timescale 1ns/1ps
`include "pcl_params.svh"
module pcl_host #(
  parameter int unsigned WAIT_CF2CK   = `PCL_CF2CK_CYC,
  parameter int unsigned WAIT_STATUS  = `PCL_STATUS_CYC,
  parameter int unsigned WAIT_CD2UM   = `PCL_CD2UM_CYC,
  parameter int unsigned USER_PERIODS = `PCL_USER_PERIODS
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // user control
  input  wire logic              start,
  input  wire logic              monitor_status,
  input  wire logic              use_user_clock,
  input  wire logic              hold_off,
  // word stream
  input  wire pcl_pkg::pcl_word_t word_in,
  input  wire logic              word_valid,
  output logic                   word_ready,
  // user status
  output logic                   busy,
  output logic                   user_mode,
  output logic                   fail,
  // device pins
  output logic                   cfg_req_n,
  input  wire logic              status_n_in,
  output logic                   status_n_out,
  output logic                   status_n_oe_n,
  input  wire logic              load_complete,
  output logic                   config_clock,
  output pcl_pkg::pcl_word_t     config_data,
  output logic                   user_init_clock
);
  import pcl_pkg::*;

  localparam int CW = `PCL_CNT_W;

  pcl_state_t      state;
  logic [CW-1:0]   cnt_r;
  logic [1:0]      st_sync_r;
  logic [1:0]      cd_sync_r;
  logic            status_s;
  logic            cd_s;
  logic [1:0]      half_r;
  logic            tick;
  logic            have_r;
  logic            aged_r;
  logic [1:0]      udiv_r;
  logic            urise;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_sync_r <= 2'h3;
      cd_sync_r <= 2'h0;
    end else begin
      st_sync_r <= {st_sync_r[0], status_n_in};
      cd_sync_r <= {cd_sync_r[0], load_complete};
    end
  end
  assign status_s = st_sync_r[1];
  assign cd_s     = cd_sync_r[1];

  // ****************************************
  // sequence state machine
  // ****************************************
  // a single down counter times every phase but the load
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      cnt_r     <= '0;
      cfg_req_n <= 1'b1;
      user_mode <= 1'b0;
      fail      <= 1'b0;
    end else if (start) begin
      // restart from scratch, any partial load is dropped
      state     <= ST_PULSE;
      cnt_r     <= CW'(`PCL_CFG_CYC - 1);
      cfg_req_n <= 1'b0;
      user_mode <= 1'b0;
      fail      <= 1'b0;
    end else begin
      case (state)
        ST_PULSE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end
          // device must have answered by now
          if (cnt_r == CW'(`PCL_CFG_CYC - 1 - `PCL_CHK_CYC) && (status_s || cd_s)) begin
            fail <= 1'b1; // request still held to its full width
          end else if (cnt_r == '0 && !hold_off) begin // stretched pulse
            state     <= fail ? ST_FAIL : ST_RELEASE;
            cfg_req_n <= 1'b1;
            cnt_r     <= monitor_status ? CW'(WAIT_STATUS) : CW'(WAIT_CF2CK);
          end
        end
        ST_RELEASE: begin
          if (hold_off) begin
            // host holds status low, so the device waits too
            cnt_r <= monitor_status ? CW'(WAIT_STATUS) : CW'(WAIT_CF2CK);
          end else if (monitor_status && status_s) begin
            state <= ST_SETTLE;
            cnt_r <= CW'(`PCL_ST2CK_CYC - 1);
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (monitor_status) begin
            // status never rose in its window
            state <= ST_FAIL;
            fail  <= 1'b1;
          end else begin
            state <= ST_LOAD; // blind wait done
          end
        end
        ST_SETTLE: begin
          if (cnt_r == '0) begin
            state <= ST_LOAD;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_LOAD: begin
          if (cd_s) begin
            state <= use_user_clock ? ST_GAP : ST_INIT;
            cnt_r <= use_user_clock ? CW'(`PCL_CD2CU_CYC - 1) : CW'(WAIT_CD2UM - 1);
          end else if (!status_s) begin
            // device flagged a load error
            state <= ST_FAIL;
            fail  <= 1'b1;
          end
        end
        ST_GAP: begin
          if (cnt_r == '0) begin
            state <= ST_INIT;
            cnt_r <= CW'(USER_PERIODS - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_INIT: begin
          if (!use_user_clock || urise) begin
            if (cnt_r == '0) begin
              state     <= ST_DONE;
              user_mode <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
        end
        ST_IDLE, ST_DONE, ST_FAIL: begin
          cnt_r <= cnt_r;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin and status outputs
  // ****************************************
  // status is only ever pulled low, never driven high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_n_out  <= 1'b0;
      status_n_oe_n <= 1'b1;
      busy          <= 1'b0;
    end else begin
      status_n_out  <= 1'b0;
      status_n_oe_n <= !(hold_off && (state == ST_PULSE || state == ST_RELEASE));
      busy          <= !(state == ST_IDLE || state == ST_DONE || state == ST_FAIL);
    end
  end

  // ****************************************
  // configuration clock and data
  // ****************************************
  // divide by four plus the word handshake keeps the clock at about 33 MHz or less, below both limits
  assign tick = (half_r == 2'(`PCL_HALF - 1));
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      half_r       <= 2'h0;
      config_clock <= 1'b0;
    end else if ((state != ST_LOAD || start || cd_s) && !config_clock) begin // high phase runs out, no runt
      half_r       <= 2'h0;
      config_clock <= 1'b0;
    end else begin
      half_r <= tick ? 2'h0 : half_r + 2'h1;
      if (tick && config_clock) begin
        config_clock <= 1'b0;
      end else if (tick && have_r && aged_r) begin
        config_clock <= 1'b1; // word captured on this edge
      end
    end
  end

  // one word per clock, held until the falling edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      have_r      <= 1'b0;
      aged_r      <= 1'b0;
      word_ready  <= 1'b0;
      config_data <= 32'h0000_0000;
    end else if (state != ST_LOAD || start || cd_s) begin
      have_r     <= 1'b0;
      aged_r     <= 1'b0;
      word_ready <= 1'b0;
    end else begin
      // aged flag gives a full cycle of setup before the rise
      aged_r <= have_r;
      if (tick && config_clock) begin
        have_r <= 1'b0;
      end else if (word_ready && word_valid) begin
        config_data <= word_in;
        have_r      <= 1'b1;
        word_ready  <= 1'b0;
      end else if (!have_r && !config_clock) begin
        word_ready <= 1'b1;
      end
    end
  end

  // ****************************************
  // user initialisation clock
  // ****************************************
  assign urise = (udiv_r == 2'(`PCL_HALF - 1)) && !user_init_clock;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      udiv_r          <= 2'h0;
      user_init_clock <= 1'b0;
    end else if (state != ST_INIT || !use_user_clock || start) begin
      udiv_r          <= 2'h0;
      user_init_clock <= 1'b0;
    end else begin
      udiv_r <= (udiv_r == 2'(`PCL_HALF - 1)) ? 2'h0 : udiv_r + 2'h1;
      if (udiv_r == 2'(`PCL_HALF - 1)) begin
        user_init_clock <= !user_init_clock;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // timing below is only meaningful for plain bitstreams
  logic [31:0] low_cnt_r;
  logic [31:0] rel_cnt_r;
  logic [31:0] sth_cnt_r;
  logic [31:0] cdh_cnt_r;
  logic        seen_r;
  logic        cclk_d_r;
  logic [1:0]  acc_r;
  logic        rise_now;
  assign rise_now = config_clock && !cclk_d_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_r <= '0;
      rel_cnt_r <= '0;
      sth_cnt_r <= '0;
      cdh_cnt_r <= '0;
      seen_r    <= 1'b0;
      cclk_d_r  <= 1'b0;
      acc_r     <= 2'h0;
    end else begin
      low_cnt_r <= cfg_req_n ? '0 : low_cnt_r + 1;
      rel_cnt_r <= !cfg_req_n ? '0 : rel_cnt_r + 1;
      sth_cnt_r <= !status_s ? '0 : sth_cnt_r + 1;
      cdh_cnt_r <= !cd_s ? '0 : cdh_cnt_r + 1;
      seen_r    <= !cfg_req_n ? 1'b0 : (seen_r || config_clock);
      cclk_d_r  <= config_clock;
      if (rise_now) begin
        acc_r <= {1'b0, (word_ready && word_valid)};
      end else if (word_ready && word_valid && acc_r != 2'h3) begin
        acc_r <= acc_r + 2'h1;
      end
    end
  end

  req_width_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(cfg_req_n) |-> $past(low_cnt_r) >= `PCL_CFG_CYC - 1)
    else $error("request low pulse too short");
  blind_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rise_now && !seen_r && !monitor_status |-> rel_cnt_r >= WAIT_CF2CK)
    else $error("first clock too soon after release");
  status_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rise_now && !seen_r && monitor_status |-> sth_cnt_r >= `PCL_ST2CK_CYC)
    else $error("first clock too soon after status high");

  sequence clk_high_s;
    config_clock [*2];
  endsequence
  sequence clk_low_s;
    !config_clock [*2];
  endsequence
  clk_rate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(config_clock) |-> clk_high_s ##1 clk_low_s)
    else $error("configuration clock too fast");
  data_setup_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(config_clock) |-> $past(config_data, 2) == config_data ##1 $stable(config_data))
    else $error("data moved around the rising edge");
  one_word_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rise_now && seen_r |-> acc_r == 2'h1)
    else $error("not exactly one word per clock");
  restart_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    start |=> !cfg_req_n && !user_mode ##1 !cfg_req_n && !config_clock)
    else $error("request did not restart the load");
  hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_off && state == ST_RELEASE && !start |=> !status_n_oe_n && state == ST_RELEASE)
    else $error("hold did not pull status low");
  user_gap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(user_init_clock) |-> cdh_cnt_r >= `PCL_CD2CU_CYC)
    else $error("user clock enabled too early");
  answer_chk_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state == ST_PULSE && !start && cnt_r == CW'(`PCL_CFG_CYC - 1 - `PCL_CHK_CYC) && status_s
    |=> fail && !cfg_req_n)
    else $error("missing device answer not flagged");

endmodule // pcl_host

// ### testbench/pcl_dev_model.sv
`timescale 1ns/1ps
module pcl_dev_model #(
  parameter int NW       = 6,
  parameter int REL_NS   = 400,
  parameter int CF2CK_NS = 1500
) (
  // host-driven pins
  input  wire logic               cfg_req_n,
  input  wire logic               config_clock,
  input  wire pcl_pkg::pcl_word_t config_data,
  input  wire logic               user_init_clock,
  // status line level and test knobs
  input  wire logic               status_line,
  input  wire logic               mute,
  input  wire logic               watch,
  // device answers and tallies
  output logic                    dev_pull,
  output logic                    load_complete,
  output logic [31:0]             words,
  output pcl_pkg::pcl_word_t      sum,
  output logic [31:0]             uclks,
  output logic [31:0]             errs
);
  import pcl_pkg::*;
  // ****************************************
  // behavioural device, scaled waits; no compression or security
  // ****************************************
  realtime t_req, t_rel, t_st, t_cd, t_ck;
  initial begin
    dev_pull = 1'b0;
    load_complete = 1'b0;
    {words, sum, uclks, errs} = '0;
    t_req = 0.0;
    t_rel = 0.0;
    t_st = 0.0;
    t_cd = 0.0;
    t_ck = 0.0;
  end
  // request low: answer fast and throw away any partial load
  always @(negedge cfg_req_n) begin
    t_req = $realtime;
    #100;
    if (!mute) begin
      dev_pull = 1'b1;
      load_complete = 1'b0;
      {words, sum, uclks, errs} = '0;
    end
  end
  // release: status low a while longer, then let go
  always @(posedge cfg_req_n) begin
    t_rel = $realtime;
    if (t_req > 0 && !mute && t_rel - t_req < 2000.0) errs = errs + 1;
    #(REL_NS);
    if (cfg_req_n === 1'b1) dev_pull = 1'b0;
  end
  always @(posedge status_line) t_st = $realtime;
  // one word per rising clock, never while the line is held low
  always @(posedge config_clock) begin
    if (words == 0 && watch && $realtime - t_st < 2000.0) errs = errs + 1;
    if (words == 0 && !watch && $realtime - t_rel < CF2CK_NS) errs = errs + 1;
    if (words != 0 && $realtime - t_ck < 10.0) errs = errs + 1;
    t_ck = $realtime;
    if (status_line && !load_complete) begin
      sum = {sum[30:0], sum[31]} ^ config_data;
      words = words + 1;
      if (words == NW) begin
        load_complete = 1'b1;
        t_cd = $realtime;
      end
    end
  end
  // user init clock must not start too soon after completion
  always @(posedge user_init_clock) begin
    if (uclks == 0 && $realtime - t_cd < 40.0) errs = errs + 1;
    uclks = uclks + 1;
  end
endmodule // pcl_dev_model

// ### testbench/parallel_config_load_sequencer_tb.sv
`timescale 1ns/1ps
module parallel_config_load_sequencer_tb;
  import pcl_pkg::*;
  localparam int NW = 6;
  localparam int CD2UM = 100;
  localparam int UP = 10;
  logic        clk_sys, reset_n, start, monitor_status, use_user_clock, hold_off, word_valid;
  logic        word_ready, busy, user_mode, fail, cfg_req_n, status_n_out, status_n_oe_n;
  logic        config_clock, user_init_clock, dev_pull, load_complete, drop, mute, acc;
  pcl_word_t   word_in, config_data, sum, exp_sum;
  logic [31:0] words, uclks, errs, seed;
  int          fails, checks, n;
  // open-drain status line with pull-up
  wire status_line = !(dev_pull || drop || (status_n_oe_n === 1'b0 && status_n_out === 1'b0));

  pcl_host #(.WAIT_CF2CK(300), .WAIT_STATUS(300), .WAIT_CD2UM(CD2UM), .USER_PERIODS(UP)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .start(start), .monitor_status(monitor_status),
    .use_user_clock(use_user_clock), .hold_off(hold_off), .word_in(word_in), .word_valid(word_valid),
    .word_ready(word_ready), .busy(busy), .user_mode(user_mode), .fail(fail), .cfg_req_n(cfg_req_n),
    .status_n_in(status_line), .status_n_out(status_n_out), .status_n_oe_n(status_n_oe_n),
    .load_complete(load_complete), .config_clock(config_clock), .config_data(config_data),
    .user_init_clock(user_init_clock));
  pcl_dev_model #(.NW(NW)) dev (
    .cfg_req_n(cfg_req_n), .config_clock(config_clock), .config_data(config_data),
    .user_init_clock(user_init_clock), .status_line(status_line), .mute(mute), .watch(monitor_status),
    .dev_pull(dev_pull), .load_complete(load_complete), .words(words), .sum(sum), .uclks(uclks),
    .errs(errs));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0020_0003 : 32'h0);
  endfunction
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // bounded wait; 0 done, 1 fail, 2 load complete, 3 two words of a fresh load in
  // (request must be released first, so the tally of the last load cannot count)
  task automatic wait_on(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (!((sel == 0 && (user_mode === 1'b1 || fail === 1'b1)) || (sel == 1 && fail === 1'b1) ||
             (sel == 2 && load_complete === 1'b1) || (sel == 3 && words >= 2 && cfg_req_n === 1'b1))) begin
      @(posedge clk_sys);
      #1;
      cnt = cnt + 1;
      if (cnt > lim) begin
        fails = fails + 1;
        $display("BAD wait %0d expected done seen timeout", sel);
        test_done();
      end
    end
  endtask
  task automatic kick();
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
  endtask
  // one full sequence, with the expected outcome worked out here
  task automatic run(input logic mon, input logic uc, input logic hold);
    monitor_status = mon;
    use_user_clock = uc;
    hold_off = hold;
    kick();
    if (hold) begin
      repeat (600) @(posedge clk_sys);
      #1;
      chk("request stretched", 0, cfg_req_n);
      chk("status held", 0, status_line);
      chk("busy while held", 1, busy);
      hold_off = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1;
      hold_off = 1'b1;
      repeat (400) @(posedge clk_sys);
      #1;
      chk("request released", 1, cfg_req_n);
      chk("status held in wait", 0, status_line);
      hold_off = 1'b0;
    end
    wait_on(2, 20000, n);
    wait_on(0, 20000, n);
    chk("fail", 0, fail);
    chk("user mode", 1, user_mode);
    chk("words", NW, words);
    chk("checksum", exp_sum, sum);
    chk("device errors", 0, errs);
    if (uc) chk("user clocks", UP, uclks);
    else chk("init window", 1, 32'(n >= CD2UM && n <= CD2UM + 8));
    @(posedge clk_sys);
    #1;
    chk("busy after done", 0, busy);
  endtask

  // ****************************************
  // clock and random word feeder
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // new word only once the old one is taken, so the offer never wavers
  always @(posedge clk_sys) begin
    acc = word_ready === 1'b1 && word_valid === 1'b1;
    if (start === 1'b1) exp_sum = '0;
    else if (acc) exp_sum = {exp_sum[30:0], exp_sum[31]} ^ word_in;
    #1;
    if (acc || !word_valid) begin
      seed = lfsr(seed);
      word_in = seed;
      word_valid = seed[3] | seed[7];
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {fails, checks} = '0;
    seed = 32'h19;
    exp_sum = '0;
    {reset_n, start, monitor_status, use_user_clock, hold_off, word_valid, drop, mute} = '0;
    word_in = 32'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    chk("reset request", 1, cfg_req_n);
    chk("reset oe", 1, status_n_oe_n);
    run(1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b0);
    run(1'b1, 1'b0, 1'b1);
    kick();
    wait_on(3, 20000, n);
    run(1'b1, 1'b1, 1'b0);
    // status pulled low mid-load must stop the host
    monitor_status = 1'b1;
    kick();
    wait_on(3, 20000, n);
    drop = 1'b1;
    wait_on(1, 60, n);
    chk("fail on status low", 1, fail);
    drop = 1'b0;
    // silent device: host must raise fail right after the answer time
    mute = 1'b1;
    kick();
    wait_on(1, 200, n);
    chk("answer deadline", 1, 32'(n >= 118 && n <= 130));
    mute = 1'b0;
    test_done();
  end
endmodule // parallel_config_load_sequencer_tb
